// ### pkg/vci_consts.svh
// constants for the vertical-blanking caption and copy-control inserter
`ifndef VCI_CONSTS_SVH
`define VCI_CONSTS_SVH

`define VCI_CLK_MHZ        40
// line numbers counted over the whole frame
`define VCI_LINE_CAP_ODD   10'h015
`define VCI_LINE_CAP_EVEN  10'h11C
`define VCI_LINE_CPY_ODD   10'h014
`define VCI_LINE_CPY_EVEN  10'h11B
// register subaddresses
`define VCI_SA_CAP_EVEN0   5'h0E
`define VCI_SA_CAP_EVEN1   5'h0F
`define VCI_SA_CAP_ODD0    5'h10
`define VCI_SA_CAP_ODD1    5'h11
// reset values
`define VCI_CAP_RESET      16'h0000
// sample levels
`define VCI_LVL_BLANK      10'h0F0
`define VCI_LVL_CAP_HI     10'h1E0
`define VCI_LVL_CPY_HI     10'h230
`define VCI_CAP_AMP        10'h0F0
// bit counts
`define VCI_RUNIN_BITS     6'h07
`define VCI_GAP_BITS       6'h02
`define VCI_START_BITS     6'h01
`define VCI_CAP_BITS       6'h10
`define VCI_REF_BITS       6'h01
`define VCI_CPY_BITS       6'h14
`define VCI_CRC_LSB        14
`define VCI_CRC_PRESET     6'h3F
// times in ns, cycles derived from the clock rate
`define VCI_CAP_BIT_NS     1986
`define VCI_CPY_BIT_NS     2237
`define VCI_START_NS       10500
`define VCI_CAP_BIT_CYC    ((`VCI_CAP_BIT_NS * `VCI_CLK_MHZ) / 1000)
`define VCI_CPY_BIT_CYC    ((`VCI_CPY_BIT_NS * `VCI_CLK_MHZ) / 1000)
`define VCI_START_CYC      ((`VCI_START_NS * `VCI_CLK_MHZ + 999) / 1000)

`endif

// ### pkg/vci_pkg.sv
// types for the vertical-blanking caption and copy-control inserter
`default_nettype none
package vci_pkg;

	typedef enum logic [3:0] {
		S_IDLE,
		S_DELAY,
		S_RUNIN,
		S_GAP,
		S_START,
		S_DATA,
		S_REF,
		S_CDATA,
		S_TAIL
	} vci_state_type;

	typedef struct packed {
		logic [9:0] level;
		logic       inserted;
	} vci_sample_type;

endpackage
`default_nettype wire

// ### design/vci_buf2.sv
// small valid/ready buffer in the output sample path
`timescale 1ns/1ps
`default_nettype none
module vci_buf2 #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 2
) (
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push_w;
	logic             pop_w;

	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign push_w      = in_valid_i && in_ready_o;
	assign pop_w       = out_valid_o && out_ready_i;
	assign out_data_o  = mem_reg[rd_ptr_reg];

	function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
		inc_ptr = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge clock_i) begin
		if (push_w) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push_w) wr_ptr_reg <= inc_ptr(wr_ptr_reg);
			if (pop_w) rd_ptr_reg <= inc_ptr(rd_ptr_reg);
			count_reg <= count_reg + (AW+1)'(push_w) - (AW+1)'(pop_w);
		end
	end

	a_buf_no_over: assert property (@(posedge clock_i) disable iff (!rstn_i)
		count_reg <= (AW+1)'(DEPTH))
		else $error("buffer count above depth");
	a_buf_held: assert property (@(posedge clock_i) disable iff (!rstn_i)
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
		else $error("buffer head moved while stalled");
endmodule
`default_nettype wire

// ### design/vci_inserter.sv
// caption and copy-control line inserter for the encoder sample stream
`timescale 1ns/1ps
`default_nettype none
`include "vci_consts.svh"

// How it works
// [RULE_01] captions go out on line 21 odd field and line 284 even field
// [RULE_02] caption line opens with seven run-in sine cycles at the bit rate
// [RULE_03] two blank bit periods after run-in, then one start bit at one
// [RULE_04] sixteen payload bits: two bytes of seven data bits and odd parity
// [RULE_05] odd field uses caption registers, line 284 uses extended registers
// [RULE_06] caption lines are generated internally; incoming pixels are dropped
// [RULE_07] registers are sampled once at line start; no extra frame of delay
// [RULE_08] host writes caption data by line 20 or line 283
// [RULE_09] host writes zeros to both caption registers when it has nothing
// [RULE_10] host keeps control code pairs in one field, pads odd messages
// [RULE_11] copy word goes out on line 20 odd field and line 283 even field
// [RULE_12] separate odd and even enables gate the copy word per field
// [RULE_13] copy word suppressed unless the encoder is in NTSC mode
// [RULE_14] copy word preceded by one reference pulse the size of a bit
// [RULE_15] reg2 gives bits 0-7, reg1 bits 8-15, reg0 low nibble bits 16-19
// [RULE_16] with crc auto on, bits 14-19 are computed from bits 0-13
// [RULE_17] crc polynomial x^6+x+1, preset to all ones per word
// [RULE_18] with crc auto off all 20 stored bits go out unchanged
// [RULE_19] word order: 6-bit word, two 4-bit words, 6-bit crc
// [RULE_20] extended caption at subaddress 0E-0F, caption at 10-11
// [RULE_21] caption bytes go out data bits lsb first, parity last
module vci_inserter (
	input  wire logic           clock_i,
	input  wire logic           rstn_i,
	input  wire logic           line_start_i,
	input  wire logic [9:0]     line_num_i,
	input  wire logic           field_even_i,
	input  wire logic           ntsc_mode_i,
	input  wire logic           crc_auto_enable_i,
	input  wire logic           copy_odd_field_enable_i,
	input  wire logic           copy_even_field_enable_i,
	input  wire logic [7:0]     copy_reg0_i,
	input  wire logic [7:0]     copy_reg1_i,
	input  wire logic [7:0]     copy_reg2_i,
	input  wire logic           cap_wr_i,
	input  wire logic [4:0]     cap_addr_i,
	input  wire logic [7:0]     cap_data_i,
	input  wire logic           pix_valid_i,
	input  wire logic [9:0]     pix_data_i,
	output logic                pix_ready_o,
	output logic                out_valid_o,
	input  wire logic           out_ready_i,
	output vci_pkg::vci_sample_type out_data_o,
	output logic                busy_o
);
	localparam logic [11:0] CAP_BIT = 12'(`VCI_CAP_BIT_CYC);
	localparam logic [11:0] CPY_BIT = 12'(`VCI_CPY_BIT_CYC);
	localparam logic [11:0] START_CYC = 12'(`VCI_START_CYC);

	vci_pkg::vci_state_type state_reg;
	vci_pkg::vci_state_type state_next;
	logic [15:0]    cap_odd_reg;
	logic [15:0]    cap_even_reg;
	logic [15:0]    cap_shift_reg;
	logic [19:0]    cpy_shift_reg;
	logic           cap_mode_reg;
	logic           ins_line_reg;
	logic [11:0]    cnt_reg;
	logic [5:0]     nbits_reg;
	logic [5:0]     nbits_next;
	logic           adv_w;
	logic           in_ready_w;
	logic           is_cap_w;
	logic           is_cpy_w;
	logic           cpy_gate_w;
	logic [11:0]    limit_w;
	logic           tick_w;
	logic           last_bit_w;
	logic [19:0]    cpy_word_w;
	logic [5:0]     crc_w;
	logic [3:0]     sin_idx_w;
	logic [9:0]     sin_lvl_w;
	logic [9:0]     level_w;
	vci_pkg::vci_sample_type smp_w;

	// odd parity over seven data bits, parity lands in bit 7
	function automatic logic [7:0] cap_byte(input logic [7:0] b);
		cap_byte = {~^b[6:0], b[6:0]};
	endfunction

	function automatic logic [5:0] crc6(input logic [13:0] d);
		logic [5:0] c;
		logic       fb;
		c = `VCI_CRC_PRESET;
		for (int i = 0; i < 14; i++) begin
			fb = d[i] ^ c[5];
			c = {c[4:0], fb} ^ {4'h0, fb, 1'b0};
		end
		crc6 = c;
	endfunction

	// raised-cosine run-in table, 0..255 over one bit period
	function automatic logic [7:0] sine_tab(input logic [3:0] i);
		case (i)
			4'h0: sine_tab = 8'h00;
			4'h1: sine_tab = 8'h0A;
			4'h2: sine_tab = 8'h25;
			4'h3: sine_tab = 8'h4F;
			4'h4: sine_tab = 8'h80;
			4'h5: sine_tab = 8'hB0;
			4'h6: sine_tab = 8'hDA;
			4'h7: sine_tab = 8'hF5;
			4'h8: sine_tab = 8'hFF;
			4'h9: sine_tab = 8'hF5;
			4'hA: sine_tab = 8'hDA;
			4'hB: sine_tab = 8'hB0;
			4'hC: sine_tab = 8'h80;
			4'hD: sine_tab = 8'h4F;
			4'hE: sine_tab = 8'h25;
			default: sine_tab = 8'h0A;
		endcase
	endfunction

	// host loads caption bytes; field timing of the loads is up to the host
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			cap_odd_reg  <= `VCI_CAP_RESET;
			cap_even_reg <= `VCI_CAP_RESET;
		end else if (cap_wr_i) begin
			case (cap_addr_i)
				`VCI_SA_CAP_EVEN0: cap_even_reg[7:0]  <= cap_data_i; // [RULE_20]
				`VCI_SA_CAP_EVEN1: cap_even_reg[15:8] <= cap_data_i; // [RULE_20]
				`VCI_SA_CAP_ODD0:  cap_odd_reg[7:0]   <= cap_data_i; // [RULE_20]
				`VCI_SA_CAP_ODD1:  cap_odd_reg[15:8]  <= cap_data_i; // [RULE_20]
				default: ;
			endcase
		end
	end

	assign is_cap_w = field_even_i ? (line_num_i == `VCI_LINE_CAP_EVEN)
		: (line_num_i == `VCI_LINE_CAP_ODD); // [RULE_01]
	assign cpy_gate_w = ntsc_mode_i && (field_even_i ? copy_even_field_enable_i
		: copy_odd_field_enable_i); // [RULE_12] [RULE_13]
	assign is_cpy_w = cpy_gate_w && (field_even_i ? (line_num_i == `VCI_LINE_CPY_EVEN)
		: (line_num_i == `VCI_LINE_CPY_ODD)); // [RULE_11]

	// copy bit 0 goes out first: word 0, word 1, word 2, then crc
	assign crc_w = crc6({copy_reg1_i[5:0], copy_reg2_i}); // [RULE_17]
	assign cpy_word_w = crc_auto_enable_i
		? {crc_w, copy_reg1_i[5:0], copy_reg2_i} // [RULE_16] [RULE_19]
		: {copy_reg0_i[3:0], copy_reg1_i, copy_reg2_i}; // [RULE_15] [RULE_18]

	// timing runs on accepted samples so a stall shifts, not truncates, a line
	assign adv_w = pix_valid_i && in_ready_w;
	assign limit_w = (state_reg == vci_pkg::S_DELAY) ? START_CYC
		: (cap_mode_reg ? CAP_BIT : CPY_BIT);
	assign tick_w = adv_w && (cnt_reg == limit_w - 12'h001);
	assign last_bit_w = (nbits_reg == 6'h01);

	always_comb begin
		state_next = state_reg;
		nbits_next = nbits_reg;
		if (tick_w) begin
			nbits_next = nbits_reg - 6'h01;
			case (state_reg)
				vci_pkg::S_DELAY: begin
					state_next = cap_mode_reg ? vci_pkg::S_RUNIN : vci_pkg::S_REF;
					nbits_next = cap_mode_reg ? `VCI_RUNIN_BITS : `VCI_REF_BITS; // [RULE_02] [RULE_14]
				end
				vci_pkg::S_RUNIN: if (last_bit_w) begin
					state_next = vci_pkg::S_GAP;
					nbits_next = `VCI_GAP_BITS; // [RULE_03]
				end
				vci_pkg::S_GAP: if (last_bit_w) begin
					state_next = vci_pkg::S_START;
					nbits_next = `VCI_START_BITS; // [RULE_03]
				end
				vci_pkg::S_START: begin
					state_next = vci_pkg::S_DATA;
					nbits_next = `VCI_CAP_BITS; // [RULE_04]
				end
				vci_pkg::S_DATA: if (last_bit_w) state_next = vci_pkg::S_TAIL;
				vci_pkg::S_REF: begin
					state_next = vci_pkg::S_CDATA;
					nbits_next = `VCI_CPY_BITS;
				end
				vci_pkg::S_CDATA: if (last_bit_w) state_next = vci_pkg::S_TAIL;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			state_reg    <= vci_pkg::S_IDLE;
			cnt_reg      <= '0;
			nbits_reg    <= '0;
			cap_mode_reg <= 1'b0;
			ins_line_reg <= 1'b0;
		end else if (line_start_i) begin
			state_reg    <= (is_cap_w || is_cpy_w) ? vci_pkg::S_DELAY : vci_pkg::S_IDLE;
			cnt_reg      <= '0;
			nbits_reg    <= '0;
			cap_mode_reg <= is_cap_w;
			ins_line_reg <= is_cap_w || is_cpy_w; // [RULE_06]
		end else begin
			state_reg <= state_next;
			nbits_reg <= nbits_next;
			if (tick_w) cnt_reg <= '0;
			else if (adv_w) cnt_reg <= cnt_reg + 12'h001;
		end
	end

	// one buffer stage: registers are taken at line start only
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			cap_shift_reg <= '0;
			cpy_shift_reg <= '0;
		end else if (line_start_i) begin
			cap_shift_reg <= field_even_i
				? {cap_byte(cap_even_reg[15:8]), cap_byte(cap_even_reg[7:0])}
				: {cap_byte(cap_odd_reg[15:8]), cap_byte(cap_odd_reg[7:0])}; // [RULE_05] [RULE_07]
			cpy_shift_reg <= cpy_word_w;
		end else if (tick_w) begin
			if (state_reg == vci_pkg::S_DATA) cap_shift_reg <= {1'b0, cap_shift_reg[15:1]}; // [RULE_21]
			if (state_reg == vci_pkg::S_CDATA) cpy_shift_reg <= {1'b0, cpy_shift_reg[19:1]}; // [RULE_19]
		end
	end

	assign sin_idx_w = 4'((16'(cnt_reg) * 16'h0010) / 16'(CAP_BIT));
	assign sin_lvl_w = `VCI_LVL_BLANK
		+ 10'((18'(`VCI_CAP_AMP) * 18'(sine_tab(sin_idx_w))) >> 8); // [RULE_02]

	always_comb begin
		case (state_reg)
			vci_pkg::S_RUNIN: level_w = sin_lvl_w;
			vci_pkg::S_START: level_w = `VCI_LVL_CAP_HI; // [RULE_03]
			vci_pkg::S_DATA:  level_w = cap_shift_reg[0] ? `VCI_LVL_CAP_HI : `VCI_LVL_BLANK; // [RULE_04]
			vci_pkg::S_REF:   level_w = `VCI_LVL_CPY_HI; // [RULE_14]
			vci_pkg::S_CDATA: level_w = cpy_shift_reg[0] ? `VCI_LVL_CPY_HI : `VCI_LVL_BLANK;
			default: level_w = `VCI_LVL_BLANK;
		endcase
	end

	assign smp_w.level    = ins_line_reg ? level_w : pix_data_i; // [RULE_06]
	assign smp_w.inserted = ins_line_reg;
	assign pix_ready_o    = in_ready_w;
	assign busy_o         = ins_line_reg;

	vci_buf2 #(
		.WIDTH ($bits(vci_pkg::vci_sample_type)),
		.DEPTH (2)
	) u_buf (
		.clock_i     (clock_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (pix_valid_i),
		.in_ready_o  (in_ready_w),
		.in_data_i   (smp_w),
		.out_valid_o (out_valid_o),
		.out_ready_i (out_ready_i),
		.out_data_o  (out_data_o)
	);

	// checks
	logic [15:0] runin_len_reg;
	always_ff @(posedge clock_i) begin
		if (!rstn_i || state_reg != vci_pkg::S_RUNIN) runin_len_reg <= '0;
		else if (adv_w) runin_len_reg <= runin_len_reg + 16'h0001;
	end

	sequence seq_cap_line;
		line_start_i && is_cap_w;
	endsequence

	a_cap_line_sel: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_01]
		seq_cap_line |=> cap_mode_reg && ins_line_reg && state_reg == vci_pkg::S_DELAY)
		else $error("caption line not selected");
	a_runin_len: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_02]
		state_reg == vci_pkg::S_RUNIN && state_next == vci_pkg::S_GAP && !line_start_i
		|-> runin_len_reg == 16'(7 * `VCI_CAP_BIT_CYC - 1))
		else $error("run-in length wrong");
	a_gap_start: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_03]
		state_reg == vci_pkg::S_GAP |-> smp_w.level == `VCI_LVL_BLANK
		&& (state_next == vci_pkg::S_GAP || state_next == vci_pkg::S_START || line_start_i))
		else $error("gap not followed by start bit");
	a_parity_odd: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_04]
		seq_cap_line |=> ^cap_shift_reg[7:0] && ^cap_shift_reg[15:8])
		else $error("caption parity not odd");
	a_field_src: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_05]
		seq_cap_line ##0 field_even_i
		|=> cap_shift_reg[6:0] == $past(cap_even_reg[6:0]))
		else $error("even caption source wrong");
	a_pix_ignored: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_06]
		cap_mode_reg && ins_line_reg |-> smp_w.inserted && smp_w.level == level_w)
		else $error("pixel leaked into caption line");
	a_copy_gate: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_13]
		line_start_i && !ntsc_mode_i && !is_cap_w |=> !ins_line_reg)
		else $error("copy word outside ntsc");
	a_crc_auto: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_16]
		line_start_i && crc_auto_enable_i
		|=> cpy_shift_reg[19:14] == crc6($past(cpy_word_w[13:0])))
		else $error("auto crc not applied");
	a_crc_off: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RULE_18]
		line_start_i && !crc_auto_enable_i
		|=> cpy_shift_reg[19:16] == $past(copy_reg0_i[3:0]))
		else $error("stored crc bits altered");
endmodule
`default_nettype wire

// ### tb/vci_host_model.sv
// host model that loads caption bytes one line ahead of their caption line
`timescale 1ns/1ps
`default_nettype none
`include "vci_consts.svh"
module vci_host_model (
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic        line_start_i,
	input  wire logic [9:0]  line_num_i,
	input  wire logic        field_even_i,
	input  wire logic [15:0] odd_data_i,
	input  wire logic [15:0] even_data_i,
	input  wire logic        odd_have_i,
	input  wire logic        even_have_i,
	output logic             cap_wr_o,
	output logic [4:0]       cap_addr_o,
	output logic [7:0]       cap_data_o
);
	logic [1:0]  step_reg;
	logic        even_reg;
	logic [15:0] sel;
	logic        have;
	wire logic   load_line = line_start_i && (line_num_i == `VCI_LINE_CPY_ODD && !field_even_i ||
		line_num_i == `VCI_LINE_CPY_EVEN && field_even_i);
	assign sel = even_reg ? even_data_i : odd_data_i;
	assign have = even_reg ? even_have_i : odd_have_i;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) step_reg <= 2'h0;
		else if (load_line) step_reg <= 2'h1;
		else if (step_reg != 2'h0) step_reg <= step_reg + 2'h1;
		if (load_line) even_reg <= field_even_i;
		cap_wr_o <= rstn_i && step_reg != 2'h0;
		// both bytes back to back in one field, low byte first
		if (step_reg == 2'h1) cap_addr_o <= even_reg ? `VCI_SA_CAP_EVEN0 : `VCI_SA_CAP_ODD0;
		else if (step_reg == 2'h2) cap_addr_o <= even_reg ? `VCI_SA_CAP_EVEN1 : `VCI_SA_CAP_ODD1;
		else cap_addr_o <= 5'h12;
		// nothing new to send: null both bytes
		if (step_reg == 2'h1) cap_data_o <= have ? sel[7:0] : 8'h00;
		else if (step_reg == 2'h2) cap_data_o <= have ? sel[15:8] : 8'h00;
		else if (step_reg == 2'h3) cap_data_o <= 8'hA5;
		else cap_data_o <= ~cap_data_o;
	end
endmodule
`default_nettype wire

// ### tb/test_vci_inserter.sv
// self-checking bench for the caption and copy-control inserter
`timescale 1ns/1ps
`default_nettype none
`include "vci_consts.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end
module test_vci_inserter;
	logic clock_i = 0, rstn_i = 0, line_start_i = 0, field_even_i = 0, ntsc_mode_i = 0;
	logic crc_auto_enable_i = 0, copy_odd_field_enable_i = 0, copy_even_field_enable_i = 0;
	logic [9:0] line_num_i = 10'h000;
	logic [7:0] r0 = 8'h00, r1 = 8'h00, r2 = 8'h00, cap_data_i;
	logic cap_wr_i, pix_valid_i = 0, out_ready_i = 1, pix_ready_o, out_valid_o, busy_o;
	logic [4:0] cap_addr_i;
	logic [15:0] odd_data = 16'h0000, even_data = 16'h0000;
	logic odd_have = 0, even_have = 0, full_seen = 0;
	logic [11:0] sent_cnt = 12'h000;
	vci_pkg::vci_sample_type out_data_o;
	vci_pkg::vci_sample_type q[$];
	int n_mismatch = 0, checks = 0, cyc = 0;
	wire logic [9:0] pix_data_i = sent_cnt[9:0] ^ 10'h155;
	always #12.5 clock_i = ~clock_i;
	vci_inserter vci_inserter_inst (.clock_i(clock_i), .rstn_i(rstn_i), .line_start_i(line_start_i),
		.line_num_i(line_num_i), .field_even_i(field_even_i), .ntsc_mode_i(ntsc_mode_i),
		.crc_auto_enable_i(crc_auto_enable_i), .copy_odd_field_enable_i(copy_odd_field_enable_i),
		.copy_even_field_enable_i(copy_even_field_enable_i), .copy_reg0_i(r0), .copy_reg1_i(r1),
		.copy_reg2_i(r2), .cap_wr_i(cap_wr_i), .cap_addr_i(cap_addr_i), .cap_data_i(cap_data_i),
		.pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i), .pix_ready_o(pix_ready_o),
		.out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o), .busy_o(busy_o));
	vci_host_model vci_host_model_inst (.clock_i(clock_i), .rstn_i(rstn_i), .line_start_i(line_start_i),
		.line_num_i(line_num_i), .field_even_i(field_even_i), .odd_data_i(odd_data),
		.even_data_i(even_data), .odd_have_i(odd_have), .even_have_i(even_have),
		.cap_wr_o(cap_wr_i), .cap_addr_o(cap_addr_i), .cap_data_o(cap_data_i));
	task automatic end_of_test();
		if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clock_i) begin
		if (line_start_i) sent_cnt <= 12'h000;
		else if (pix_valid_i && pix_ready_o) sent_cnt <= sent_cnt + 12'h001;
		if (out_valid_o && out_ready_i) q.push_back(out_data_o);
		if (!pix_ready_o) full_seen <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	function automatic logic [19:0] cpy_word(input logic auto);
		logic [19:0] w;
		logic [5:0] c;
		logic fb;
		w = {r0[3:0], r1, r2};
		c = `VCI_CRC_PRESET;
		for (int i = 0; i < 14; i++) begin
			fb = w[i] ^ c[5];
			c = {c[4:1], c[0] ^ fb, fb};
		end
		if (auto) w[19:14] = c;
		return w;
	endfunction
	// kind 0 passes pixels, 1 is a caption line, 2 a copy line
	task automatic run_line(input logic [9:0] num, input logic ev, input int kind, input logic [19:0] w);
		int i;
		logic [7:0] b;
		logic bv;
		pix_valid_i = 0;
		out_ready_i = 1;
		repeat (6) @(posedge clock_i);
		#2;
		q.delete();
		line_num_i = num;
		field_even_i = ev;
		line_start_i = 1;
		@(posedge clock_i);
		#2;
		line_start_i = 0;
		`CHK(busy_o, kind != 0)
		// short receiver stalls fill the buffer so refusal is exercised
		for (i = 0; i < 20000 && sent_cnt < 12'hA28; i++) begin
			pix_valid_i = 1;
			out_ready_i = (i % 40) < 37;
			@(posedge clock_i);
			#2;
		end
		pix_valid_i = 0;
		out_ready_i = 1;
		repeat (6) @(posedge clock_i);
		#2;
		`CHK(q.size(), 2600)
		if (kind == 0) for (i = 100; i < 2600; i += 500) `CHK(q[i], {10'(i) ^ 10'h155, 1'b0})
		else `CHK(q[200], {`VCI_LVL_BLANK, 1'b1})
		if (kind == 1) begin
			for (i = 0; i < 7; i++) `CHK(q[459 + i * 79].level > `VCI_LVL_BLANK, 1'b1)
			`CHK(q[420 + 8 * 79], {`VCI_LVL_BLANK, 1'b1})
			`CHK(q[459 + 9 * 79], {`VCI_LVL_CAP_HI, 1'b1})
			for (i = 0; i < 16; i++) begin
				b = i < 8 ? w[7:0] : w[15:8];
				bv = (i % 8) < 7 ? b[i % 8] : ~^b[6:0];
				`CHK(q[459 + (10 + i) * 79].level, bv ? `VCI_LVL_CAP_HI : `VCI_LVL_BLANK)
			end
		end
		if (kind == 2) begin
			`CHK(q[464], {`VCI_LVL_CPY_HI, 1'b1})
			for (i = 0; i < 20; i++) `CHK(q[464 + (1 + i) * 89].level, w[i] ? `VCI_LVL_CPY_HI : `VCI_LVL_BLANK)
		end
	endtask
	initial begin
		repeat (6) @(posedge clock_i);
		#2;
		`CHK(out_valid_o, 1'b0)
		`CHK(pix_ready_o, 1'b1)
		`CHK(busy_o, 1'b0)
		rstn_i = 1;
		ntsc_mode_i = 1;
		crc_auto_enable_i = 1;
		copy_odd_field_enable_i = 1;
		{r0, r1, r2} = {8'h0A, 8'h3C, 8'h96};
		{odd_data, even_data, odd_have, even_have} = {16'h6241, 16'h2C13, 2'b11};
		run_line(`VCI_LINE_CPY_ODD, 0, 2, cpy_word(1));
		run_line(`VCI_LINE_CAP_ODD, 0, 1, {4'h0, odd_data});
		crc_auto_enable_i = 0;
		copy_even_field_enable_i = 1;
		r0 = 8'hF5;
		run_line(`VCI_LINE_CPY_EVEN, 1, 2, cpy_word(0));
		run_line(`VCI_LINE_CAP_EVEN, 1, 1, {4'h0, even_data});
		run_line(10'h016, 0, 0, 20'h00000);
		copy_odd_field_enable_i = 0;
		odd_have = 0;
		run_line(`VCI_LINE_CPY_ODD, 0, 0, 20'h00000);
		run_line(`VCI_LINE_CAP_ODD, 0, 1, 20'h00000);
		ntsc_mode_i = 0;
		run_line(`VCI_LINE_CPY_EVEN, 1, 0, 20'h00000);
		`CHK(full_seen, 1'b1)
		end_of_test();
	end
endmodule
`default_nettype wire
